/* logic/dmf_pkg.sv */
// Constants shared by the drive motion fault monitor and its pulse-rate checker.
// Assumes one 100 MHz control clock and inputs already synchronous to it.
// Behaviour
// - A gearing pulse rate above the maximum input frequency latches the pulse over-frequency fault and disables the drive.
// - A stall condition holds while current is above the continuous setting and above 0.9 of the peak limit and velocity is below the stall threshold.
// - A stall condition that lasts longer than the stall duration threshold latches the stall fault and disables the drive.
// - A fieldbus target that would exceed the velocity limit is rejected, latches the velocity fault and disables the drive.
// - A fieldbus target that would exceed the acceleration or deceleration limit is rejected, latches the accel fault and disables the drive.
// - Loss of the fieldbus link latches the cable disconnect fault and disables the drive.
`default_nettype none
package dmf_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CUR_W = 16;
   localparam int VEL_W = 16;
   localparam int POS_W = 32;
   localparam int TIME_W = 32;
   // Pulse-rate measurement window and the highest legal input frequency
   localparam int PULSE_WIN_NS = 10000;
   localparam int PULSE_MAX_FREQ_KHZ = 4000;
   localparam int WIN_W = 10;
   localparam int EDGE_W = 8;
   localparam logic [WIN_W-1:0] PULSE_WIN_LAST = WIN_W'(PULSE_WIN_NS / CLK_PERIOD_NS - 1);
   localparam logic [EDGE_W-1:0] PULSE_MAX_EDGES = EDGE_W'(PULSE_MAX_FREQ_KHZ * PULSE_WIN_NS / 1000000);
   // Stall current ratio, 9 of 10 of the peak limit
   localparam logic [3:0] STALL_NUM = 4'h9;
   localparam logic [3:0] STALL_DEN = 4'hA;
   localparam logic [POS_W-1:0] TARGET_RST = 32'h0;
   localparam logic [TIME_W-1:0] STALL_CNT_MAX = 32'hFFFFFFFF;
endpackage
`default_nettype wire

/* logic/dmf_pulse_if.sv */
// Carries the gearing pulse line to the rate checker and its over-rate event back.
// Assumes both ends sit in the same clock domain.
`default_nettype none
interface dmf_pulse_if;
   logic pulse_in;
   logic over_freq;
   modport mon (input pulse_in, output over_freq);
   modport top (output pulse_in, input over_freq);
endinterface
`default_nettype wire

/* logic/dmf_pulse_monitor.sv */
// Gearing pulse rate checker: counts rising edges in a fixed window.
// Assumes the pulse line is synchronous to clk_sys.
`default_nettype none
module dmf_pulse_monitor (
   input wire logic clk_sys,
   input wire logic rstn,
   dmf_pulse_if.mon pif
);
   import dmf_pkg::*;

   logic prev_q;
   logic [WIN_W-1:0] win_cnt_q;
   logic [EDGE_W-1:0] edge_cnt_q;
   logic over_q;
   logic rise;
   logic win_end;

   assign rise = pif.pulse_in & ~prev_q;
   assign win_end = (win_cnt_q == PULSE_WIN_LAST);
   assign pif.over_freq = over_q;

   // Edge detector
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= pif.pulse_in;
      end
   end

   // Free-running window timer
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         win_cnt_q <= '0;
      end else if (win_end) begin
         win_cnt_q <= '0;
      end else begin
         win_cnt_q <= win_cnt_q + WIN_W'(1);
      end
   end

   // Edge count saturates one above the limit so the event fires once a window
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         edge_cnt_q <= '0;
      end else if (win_end) begin
         edge_cnt_q <= {{(EDGE_W-1){1'b0}}, rise};
      end else if (rise && edge_cnt_q <= PULSE_MAX_EDGES) begin
         edge_cnt_q <= edge_cnt_q + EDGE_W'(1);
      end
   end

   // Report as soon as the count passes the limit, not at window end
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         over_q <= 1'b0;
      end else begin
         over_q <= rise && !win_end && (edge_cnt_q == PULSE_MAX_EDGES);
      end
   end

   a_over_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
      over_q |-> $past(rise) && $past(edge_cnt_q) == PULSE_MAX_EDGES)
      else $error("over-frequency event without limit crossing");

   a_window_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
      win_end |=> win_cnt_q == '0 && edge_cnt_q <= EDGE_W'(1))
      else $error("window did not restart");
endmodule
`default_nettype wire

/* logic/dmf_fault_monitor.sv */
// Drive motion fault monitor: pulse rate, stall, fieldbus limits and link loss.
// Assumes all inputs are synchronous to clk_sys; limits are held steady by software.
`default_nettype none
module dmf_fault_monitor (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic pulse_in,
   input wire logic [dmf_pkg::CUR_W-1:0] motor_current,
   input wire logic [dmf_pkg::VEL_W-1:0] motor_velocity,
   input wire logic [dmf_pkg::CUR_W-1:0] continuous_current_setting,
   input wire logic [dmf_pkg::CUR_W-1:0] peak_current_limit,
   input wire logic [dmf_pkg::VEL_W-1:0] stall_velocity_threshold,
   input wire logic [dmf_pkg::TIME_W-1:0] stall_duration_threshold,
   input wire logic cmd_valid,
   input wire logic [dmf_pkg::POS_W-1:0] cmd_target,
   input wire logic [dmf_pkg::POS_W-1:0] velocity_limit,
   input wire logic [dmf_pkg::POS_W-1:0] accel_limit,
   input wire logic [dmf_pkg::POS_W-1:0] decel_limit,
   input wire logic link_up,
   input wire logic fault_clear,
   input wire logic drive_enable_req,
   output logic drive_enable,
   output logic pulse_overfrequency_fault,
   output logic stall_fault,
   output logic fieldbus_velocity_fault,
   output logic accel_limit_fault,
   output logic cable_disconnect_fault,
   output logic stall_active,
   output logic cmd_accept,
   output logic cmd_reject,
   output logic [dmf_pkg::POS_W-1:0] target_position
);
   import dmf_pkg::*;

   // Magnitude of a signed 33-bit difference
   function automatic logic [POS_W:0] mag(input logic [POS_W:0] v);
      mag = v[POS_W] ? (~v + (POS_W+1)'(1)) : v;
   endfunction

   dmf_pulse_if pif ();

   logic pulse_fault_q, stall_fault_q, vel_fault_q, acc_fault_q, cable_fault_q;
   logic pulse_fault_d, stall_fault_d, vel_fault_d, acc_fault_d, cable_fault_d;
   logic drive_enable_q, stall_active_q, cmd_accept_q, cmd_reject_q, link_prev_q;
   logic [TIME_W-1:0] stall_cnt_q;
   logic [POS_W-1:0] target_q;
   logic [POS_W:0] prev_vel_q;
   logic any_fault, stall_cond, stall_set, link_lost;
   logic [19:0] cur_scaled, lim_scaled;
   logic [POS_W:0] step, vel, dvel;
   logic cmd_live, vel_bad, acc_bad;

   assign pif.pulse_in = pulse_in;

   dmf_pulse_monitor u_pulse (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .pif(pif)
   );

   // Stall condition: compare 10*I against 9*limit to avoid a divider
   assign cur_scaled = {4'h0, motor_current} * {16'h0, STALL_DEN};
   assign lim_scaled = {4'h0, peak_current_limit} * {16'h0, STALL_NUM};
   assign stall_cond = (motor_current > continuous_current_setting) && (cur_scaled > lim_scaled)
      && (motor_velocity < stall_velocity_threshold);
   assign stall_set = stall_cond && (stall_cnt_q >= stall_duration_threshold);

   // Fieldbus checks: step per command is the velocity, change of step the accel
   assign any_fault = pulse_fault_q | stall_fault_q | vel_fault_q | acc_fault_q | cable_fault_q;
   assign cmd_live = cmd_valid && !any_fault;
   assign step = {cmd_target[POS_W-1], cmd_target} - {target_q[POS_W-1], target_q};
   assign vel = mag(step);
   assign dvel = mag(vel - prev_vel_q);
   assign vel_bad = vel > {1'b0, velocity_limit};
   assign acc_bad = (vel > prev_vel_q) ? (dvel > {1'b0, accel_limit})
      : (dvel > {1'b0, decel_limit});
   assign link_lost = link_prev_q && !link_up;

   // Next fault state; a new event beats a simultaneous clear
   always_comb begin
      pulse_fault_d = pif.over_freq | (pulse_fault_q & ~fault_clear);
      stall_fault_d = stall_set | (stall_fault_q & ~fault_clear);
      vel_fault_d = (cmd_live & vel_bad) | (vel_fault_q & ~fault_clear);
      acc_fault_d = (cmd_live & acc_bad) | (acc_fault_q & ~fault_clear);
      cable_fault_d = link_lost | (cable_fault_q & ~fault_clear);
   end

   // Fault latches
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pulse_fault_q <= 1'b0;
         stall_fault_q <= 1'b0;
         vel_fault_q <= 1'b0;
         acc_fault_q <= 1'b0;
         cable_fault_q <= 1'b0;
      end else begin
         pulse_fault_q <= pulse_fault_d;
         stall_fault_q <= stall_fault_d;
         vel_fault_q <= vel_fault_d;
         acc_fault_q <= acc_fault_d;
         cable_fault_q <= cable_fault_d;
      end
   end

   // Drive enable follows the request only while no fault is about to be held
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         drive_enable_q <= 1'b0;
      end else begin
         drive_enable_q <= drive_enable_req & ~(pulse_fault_d | stall_fault_d | vel_fault_d
            | acc_fault_d | cable_fault_d);
      end
   end

   // Stall duration counter, saturating so a long stall cannot wrap back to zero
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         stall_cnt_q <= '0;
         stall_active_q <= 1'b0;
      end else begin
         stall_active_q <= stall_cond;
         if (!stall_cond) begin
            stall_cnt_q <= '0;
         end else if (stall_cnt_q != STALL_CNT_MAX) begin
            stall_cnt_q <= stall_cnt_q + TIME_W'(1);
         end
      end
   end

   // Command acceptance; commands arriving while a fault is held are ignored
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         target_q <= TARGET_RST;
         prev_vel_q <= '0;
         cmd_accept_q <= 1'b0;
         cmd_reject_q <= 1'b0;
      end else begin
         cmd_accept_q <= cmd_live && !vel_bad && !acc_bad;
         cmd_reject_q <= cmd_live && (vel_bad || acc_bad);
         if (cmd_live && !vel_bad && !acc_bad) begin
            target_q <= cmd_target;
            prev_vel_q <= vel;
         end
      end
   end

   // Link level history for loss detection
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         link_prev_q <= 1'b0;
      end else begin
         link_prev_q <= link_up;
      end
   end

   assign drive_enable = drive_enable_q;
   assign pulse_overfrequency_fault = pulse_fault_q;
   assign stall_fault = stall_fault_q;
   assign fieldbus_velocity_fault = vel_fault_q;
   assign accel_limit_fault = acc_fault_q;
   assign cable_disconnect_fault = cable_fault_q;
   assign stall_active = stall_active_q;
   assign cmd_accept = cmd_accept_q;
   assign cmd_reject = cmd_reject_q;
   assign target_position = target_q;

   sequence s_link_drop;
      link_up ##1 !link_up;
   endsequence

   sequence s_bad_vel_cmd;
      cmd_valid && !any_fault && vel_bad;
   endsequence

   a_pulse_fault_set: assert property (@(posedge clk_sys) disable iff (!rstn)
      pif.over_freq |=> pulse_fault_q && !drive_enable_q)
      else $error("over-frequency did not fault the drive");

   a_stall_cond_def: assert property (@(posedge clk_sys) disable iff (!rstn)
      stall_active_q |-> $past(motor_current > continuous_current_setting)
         && $past(cur_scaled > lim_scaled)
         && $past(motor_velocity < stall_velocity_threshold))
      else $error("stall flagged without its condition");

   a_stall_needs_time: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(stall_fault_q) |-> $past(stall_cond) && $past(stall_cnt_q) >= $past(stall_duration_threshold))
      else $error("stall fault before duration elapsed");

   a_vel_reject: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_bad_vel_cmd |=> cmd_reject_q && !cmd_accept_q && vel_fault_q && !drive_enable_q)
      else $error("over-velocity target not rejected");

   a_reject_holds_target: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_reject_q |-> target_q == $past(target_q))
      else $error("rejected target was taken");

   a_acc_reject: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_valid && !any_fault && !vel_bad && acc_bad |=> acc_fault_q && cmd_reject_q)
      else $error("accel violation not rejected");

   a_cable_loss: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_link_drop |=> cable_fault_q && !drive_enable_q)
      else $error("link loss did not fault the drive");

   a_fault_latched: assert property (@(posedge clk_sys) disable iff (!rstn)
      any_fault && !fault_clear |=> any_fault [*1] ##0 !drive_enable_q)
      else $error("fault dropped without clear");

   // Quiet side of each rule: no stale stall count, no stray accept, a clear really releases
   a_stall_count_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
      !stall_cond |=> stall_cnt_q == '0)
      else $error("stall count kept without condition");

   a_accept_takes: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_live && !vel_bad && !acc_bad |=> cmd_accept_q && !cmd_reject_q && target_q == $past(cmd_target))
      else $error("legal target not taken");

   a_busy_ignores: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_valid && any_fault |=> !cmd_accept_q && !cmd_reject_q && $stable(target_q))
      else $error("command acted on while faulted");

   a_clear_releases: assert property (@(posedge clk_sys) disable iff (!rstn)
      fault_clear && drive_enable_req && !(pif.over_freq || stall_set || link_lost
         || (cmd_live && (vel_bad || acc_bad))) |=> !any_fault && drive_enable_q)
      else $error("clear did not release the drive");
endmodule
`default_nettype wire

/* sim/dmf_ctrl_model.sv */
// Controller-side model: gearing pulses, fieldbus targets, link and enables.
// Assumes the bench calls its tasks from one thread, on falling edges only.
`default_nettype none
module dmf_ctrl_model (
   input wire logic clk_sys,
   input wire logic fault,
   output logic pulse_in,
   output logic cmd_valid,
   output logic [dmf_pkg::POS_W-1:0] cmd_target,
   output logic link_up,
   output logic fault_clear,
   output logic drive_enable_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle levels: link present, drive requested, no strobe
   initial begin
      pulse_in = 1'b0;
      cmd_valid = 1'b0;
      cmd_target = 32'h0;
      link_up = 1'b1;
      fault_clear = 1'b0;
      drive_enable_req = 1'b1;
   end
   // One-cycle strobe; target is scrambled after, so a stale value never looks valid
   task automatic send(input logic [31:0] t);
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd_target = t;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      cmd_target = ~t;
   endtask
   // Pulses one cycle high; backs off once the rate fault shows
   task automatic pulses(input int n, input int gap);
      repeat (n) begin
         if (fault) return;
         @(negedge clk_sys);
         pulse_in = 1'b1;
         @(negedge clk_sys);
         pulse_in = 1'b0;
         repeat (gap) @(negedge clk_sys);
      end
   endtask
   // Fault clear held for one cycle
   task automatic clear;
      @(negedge clk_sys);
      fault_clear = 1'b1;
      @(negedge clk_sys);
      fault_clear = 1'b0;
   endtask
   task automatic set_link(input logic v);
      @(negedge clk_sys);
      link_up = v;
   endtask
endmodule
`default_nettype wire

/* sim/dmf_fault_monitor_test.sv */
// Self-checking bench for the drive motion fault monitor against a reference model.
// Assumes the controller model drives command side; the bench drives limits and feedback.
`default_nettype none
module dmf_fault_monitor_test;
   timeunit 1ns;
   timeprecision 1ps;
   import dmf_pkg::*;
   logic clk_sys, rstn;
   logic [CUR_W-1:0] cur, cont, peak;
   logic [VEL_W-1:0] vel, svel;
   logic [TIME_W-1:0] thr;
   logic [POS_W-1:0] vlim, alim, dlim;
   wire pulse_in, cmd_valid, link_up, fault_clear, drive_enable_req, acc, rej, den, sact;
   wire [POS_W-1:0] cmd_target, tpos;
   wire [4:0] flt;
   int miscompares = 0;
   int checks = 0;
   logic [15:0] seed = 16'h004C;
   logic [4:0] efv = 5'h0;
   longint et = 0;
   longint epv = 0;
   bit pc = 0;
   int run = 0;
   // Directed targets: accepts, an accel reject, two double rejects, more accepts, then a decel reject
   int vals[9] = '{200, 500, 700, 1400, 3000, 2900, 950, 1250, 1260};
   dmf_ctrl_model ctl (.clk_sys(clk_sys), .fault(flt[4]), .pulse_in(pulse_in), .cmd_valid(cmd_valid),
      .cmd_target(cmd_target), .link_up(link_up), .fault_clear(fault_clear), .drive_enable_req(drive_enable_req));
   dmf_fault_monitor dut (.clk_sys(clk_sys), .rstn(rstn), .pulse_in(pulse_in), .motor_current(cur),
      .motor_velocity(vel), .continuous_current_setting(cont), .peak_current_limit(peak),
      .stall_velocity_threshold(svel), .stall_duration_threshold(thr), .cmd_valid(cmd_valid),
      .cmd_target(cmd_target), .velocity_limit(vlim), .accel_limit(alim), .decel_limit(dlim), .link_up(link_up),
      .fault_clear(fault_clear), .drive_enable_req(drive_enable_req), .drive_enable(den),
      .pulse_overfrequency_fault(flt[4]), .stall_fault(flt[3]), .fieldbus_velocity_fault(flt[2]),
      .accel_limit_fault(flt[1]), .cable_disconnect_fault(flt[0]), .stall_active(sact), .cmd_accept(acc),
      .cmd_reject(rej), .target_position(tpos));
   // 100 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic note(input bit bad, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (bad) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Faults, strobes and enable in one word; enable follows request and no fault
   task automatic cmp_flags(input bit ea, input bit er);
      logic [7:0] got, exp;
      got = {flt, acc, rej, den};
      exp = {efv, ea, er, drive_enable_req & ~|efv};
      note(got !== exp, {24'h0, got}, {24'h0, exp});
   endtask
   task automatic cmp_pos(input logic [31:0] exp);
      note(tpos !== exp, tpos, exp);
   endtask
   task automatic clr;
      ctl.clear();
      efv = 5'h0;
      cmp_flags(1'b0, 1'b0);
   endtask
   // Reference: step against last accepted target, ignored while any fault stands
   task automatic do_cmd(input longint t);
      longint st, v;
      bit fv, fa, live;
      live = ~|efv;
      ctl.send(t[31:0]);
      st = t - et;
      v = st < 0 ? -st : st;
      fv = v > vlim;
      fa = v > epv ? v - epv > alim : epv - v > dlim;
      if (live && (fv || fa)) efv[2:1] = {fv, fa};
      else if (live) begin
         et = t;
         epv = v;
      end
      cmp_flags(live && !(fv || fa), live && (fv || fa));
      cmp_pos(et[31:0]);
   endtask
   task automatic try_cmd(input longint t);
      do_cmd(t);
      if (|efv) begin
         do_cmd(t);
         clr;
      end
   endtask
   // Stall reference: checks the previous cycle, then applies new feedback
   task automatic stall(input int i, input int v, input int n);
      repeat (n) begin
         @(negedge clk_sys);
         if (pc && run >= thr) efv[3] = 1'b1;
         run = pc ? run + 1 : 0;
         note(sact !== pc, {31'h0, sact}, {31'h0, pc});
         cmp_flags(1'b0, 1'b0);
         cur = i[15:0];
         vel = v[15:0];
         pc = cur > cont && 10 * cur > 9 * peak && vel < svel;
      end
   endtask
   task automatic wrap_up;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog well beyond the expected few thousand cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      wrap_up;
   end
   // Main sequence
   initial begin
      rstn = 1'b0;
      {cur, vel, thr} = '0;
      cont = 16'h03E8;
      peak = 16'h07D0;
      svel = 16'h0032;
      thr = 32'h5;
      vlim = 32'h3E8;
      alim = 32'h12C;
      dlim = 32'hC8;
      repeat (16) @(negedge clk_sys);
      rstn = 1'b1;
      @(negedge clk_sys);
      cmp_flags(1'b0, 1'b0);
      cmp_pos(32'h0);
      foreach (vals[k]) try_cmd(vals[k]);
      repeat (14) begin
         seed = lfsr(seed);
         alim = {24'h0, seed[15:8]} + 32'h64;
         dlim = alim;
         try_cmd(et + longint'(seed[10:0]) - 1024);
      end
      stall(1800, 0, 6);
      stall(1801, 10, 5);
      stall(1801, 50, 1);
      stall(1801, 49, 6);
      stall(0, 0, 2);
      clr;
      thr = 32'h3;
      stall(1801, 0, 4);
      stall(0, 0, 2);
      clr;
      ctl.pulses(100, 24);
      cmp_flags(1'b0, 1'b0);
      ctl.pulses(600, 0);
      @(negedge clk_sys);
      efv[4] = 1'b1;
      cmp_flags(1'b0, 1'b0);
      clr;
      ctl.set_link(1'b0);
      @(negedge clk_sys);
      efv[0] = 1'b1;
      cmp_flags(1'b0, 1'b0);
      clr;
      ctl.set_link(1'b1);
      // Second reset in mid-run: faults, strobes and the held target must all restart
      rstn = 1'b0;
      repeat (2) @(negedge clk_sys);
      rstn = 1'b1;
      et = 0;
      epv = 0;
      @(negedge clk_sys);
      cmp_flags(1'b0, 1'b0);
      cmp_pos(32'h0);
      try_cmd(et + 100);
      wrap_up;
   end
endmodule
`default_nettype wire
